// >>> hw/vlm_pkg.sv
// constants for the output-voltage limit, margin, current offset and overvoltage register group
// assumes one 125 MHz clock and a command port fed by the bus slave on the same clock
package vlm_pkg;
    // command codes of this group
    localparam logic [7:0]  CMD_CEILING     = 8'h24;
    localparam logic [7:0]  CMD_MARGIN_HIGH = 8'h25;
    localparam logic [7:0]  CMD_MARGIN_LOW  = 8'h26;
    localparam logic [7:0]  CMD_CAL_OFFSET  = 8'h39;
    localparam logic [7:0]  CMD_OV_ACTION   = 8'h41;
    // reset values and fixed read values
    localparam logic [7:0]  CEILING_RST     = 8'hff;
    localparam logic [7:0]  MARGIN_HIGH_RST = 8'h00;
    localparam logic [7:0]  MARGIN_LOW_RST  = 8'h00;
    localparam logic [15:0] CAL_OFFSET_RST  = 16'h0000;
    localparam logic [7:0]  OV_ACTION_VAL   = 8'h80;
    localparam logic [7:0]  UPPER_ZERO      = 8'h00;
    // field layout of the linear offset
    localparam int          CAL_EXP_MSB     = 15;
    localparam int          CAL_EXP_LSB     = 11;
    localparam int          CAL_MANT_MSB    = 10;
    localparam int          CAL_MANT_LSB    = 0;
    // current telemetry is signed with this many fraction bits (1/16 A)
    localparam int          IOUT_FRAC_BITS  = 4;
    // status bit positions
    localparam int          SB_OTHER        = 0;
    localparam int          SB_VOUT_OV      = 5;
    localparam int          SW_VOUT         = 15;
    localparam int          SV_OV_FAULT     = 7;
    localparam int          SV_MAX_WARN     = 3;
    // operation modes chosen by the operation command
    localparam logic [1:0]  OP_NOMINAL      = 2'h0;
    localparam logic [1:0]  OP_MARGIN_LOW   = 2'h1;
    localparam logic [1:0]  OP_MARGIN_HIGH  = 2'h2;
    // protocol selection by the vendor command
    localparam logic [1:0]  PSEL_STRAP      = 2'h0;
    localparam logic [1:0]  PSEL_FORCE_A    = 2'h1;
    localparam logic [1:0]  PSEL_FORCE_B    = 2'h2;
    // cycles after reset release before the strap is caught
    localparam logic [1:0]  STRAP_WAIT      = 2'h3;
    // power state, one-hot
    typedef enum logic [1:0] {
        ST_RUN    = 2'b01,
        ST_OV_OFF = 2'b10
    } vlm_pwr_e;
endpackage

// >>> hw/vlm_sync2.sv
// two-flop synchroniser for one asynchronous level
// assumes the level is slow against mclk
`timescale 1ns/1ns
module vlm_sync2 (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta; // first stage, read only by the second

    // plain two-stage capture
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> hw/vlm_lin2fix.sv
// converts a linear-format value (5-bit exponent, 11-bit mantissa) to fixed point
// assumes the result carries vlm_pkg::IOUT_FRAC_BITS fraction bits; pure logic
`timescale 1ns/1ns
module vlm_lin2fix (
    input  wire logic [4:0]  exp_in,
    input  wire logic [10:0] mant_in,
    output logic signed [31:0] fix_out
);
    logic signed [31:0] mant_ext; // sign-extended mantissa
    logic signed [6:0]  shift;    // exponent plus fraction bits, -12..19

    // shift the mantissa by the exponent; bits below 1/16 A are dropped
    always_comb begin
        mant_ext = 32'(signed'(mant_in));
        shift    = 7'(signed'(exp_in)) + 7'(vlm_pkg::IOUT_FRAC_BITS);
        if (shift >= 0) begin
            fix_out = mant_ext <<< shift[4:0];
        end else begin
            fix_out = mant_ext >>> 5'(-shift);
        end
    end
endmodule

// >>> hw/vlm_regs.sv
// command registers for output ceiling, margins, current offset and overvoltage response
// assumes the bus slave presents decoded commands on mclk; analog sense lines are async
`timescale 1ns/1ns
module vlm_regs (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid,
    output logic             rsp_nack,
    output logic [15:0]      rsp_rdata,
    input  wire logic [1:0]  op_mode,
    input  wire logic [7:0]  vout_cmd_vid,
    input  wire logic        ramp_protocol_strap,
    input  wire logic [1:0]  vendor_protocol_select_cmd,
    input  wire logic        ov_detect,
    input  wire logic        fault_clear,
    input  wire logic [15:0] iout_raw,
    output logic [15:0]      iout_report,
    output logic [7:0]       vid_target,
    output logic             vid_protocol,
    output logic             switch_enable,
    output logic [7:0]       status_byte,
    output logic [15:0]      status_word,
    output logic [7:0]       status_vout,
    output logic             host_alert_out,
    output logic             host_alert_oe
);
    logic [7:0]         ceiling;       // output voltage ceiling VID
    logic [7:0]         margin_high;   // margin-high target VID
    logic [7:0]         margin_low;    // margin-low target VID
    logic [15:0]        cal_offset;    // linear current offset
    logic               ov_sync;       // synchronised overvoltage level
    logic               strap_sync;    // synchronised protocol strap
    logic               strap_held;    // strap caught after reset
    logic [1:0]         strap_cnt;     // wait for the synchroniser to fill
    logic               strap_done;    // strap has been caught
    logic signed [31:0] cal_fix;       // offset in 1/16 A
    logic signed [32:0] iout_sum;      // raw plus offset, wide
    logic [7:0]         requested;     // target before the clamp
    logic               over_ceiling;  // requested above ceiling
    logic               code_known;    // command belongs to this group
    logic [15:0]        read_val;      // read mux output
    logic [7:0]         next_byte;     // status byte after set/clear
    logic [7:0]         next_vout;     // vout status after set/clear
    vlm_pkg::vlm_pwr_e  state;         // power state
    vlm_pkg::vlm_pwr_e  next_state;    // power state to come

    vlm_sync2 u_ov_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (ov_detect),
        .sync_out (ov_sync)
    );

    vlm_sync2 u_strap_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (ramp_protocol_strap),
        .sync_out (strap_sync)
    );

    vlm_lin2fix u_cal (
        .exp_in  (cal_offset[vlm_pkg::CAL_EXP_MSB:vlm_pkg::CAL_EXP_LSB]),
        .mant_in (cal_offset[vlm_pkg::CAL_MANT_MSB:vlm_pkg::CAL_MANT_LSB]),
        .fix_out (cal_fix)
    );

    // register writes; only the low byte of a VID word is kept
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ceiling     <= vlm_pkg::CEILING_RST;
            margin_high <= vlm_pkg::MARGIN_HIGH_RST;
            margin_low  <= vlm_pkg::MARGIN_LOW_RST;
            cal_offset  <= vlm_pkg::CAL_OFFSET_RST;
        end else if (cmd_wr) begin
            case (cmd_code)
                vlm_pkg::CMD_CEILING: begin
                    ceiling <= cmd_wdata[7:0];
                end
                vlm_pkg::CMD_MARGIN_HIGH: begin
                    margin_high <= cmd_wdata[7:0];
                end
                vlm_pkg::CMD_MARGIN_LOW: begin
                    margin_low <= cmd_wdata[7:0];
                end
                vlm_pkg::CMD_CAL_OFFSET: begin
                    cal_offset <= cmd_wdata;
                end
                default: begin
                    // response register and unknown codes store nothing
                end
            endcase
        end
    end

    // decode and read mux; upper bytes of VID words read zero
    always_comb begin
        code_known = 1'b1;
        case (cmd_code)
            vlm_pkg::CMD_CEILING:     read_val = {vlm_pkg::UPPER_ZERO, ceiling};
            vlm_pkg::CMD_MARGIN_HIGH: read_val = {vlm_pkg::UPPER_ZERO, margin_high};
            vlm_pkg::CMD_MARGIN_LOW:  read_val = {vlm_pkg::UPPER_ZERO, margin_low};
            vlm_pkg::CMD_CAL_OFFSET:  read_val = cal_offset;
            vlm_pkg::CMD_OV_ACTION: begin
                read_val = {vlm_pkg::UPPER_ZERO, vlm_pkg::OV_ACTION_VAL};
            end
            default: begin
                read_val   = 16'h0000;
                code_known = 1'b0;
            end
        endcase
    end

    // one-cycle answer to every read or write; a write to the response
    // register is accepted but has no effect, so the shutdown stays fixed
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_nack  <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= cmd_rd | cmd_wr;
            rsp_nack  <= (cmd_rd | cmd_wr) & ~code_known;
            rsp_rdata <= cmd_rd ? read_val : 16'h0000;
        end
    end

    // catch the strap once the synchroniser holds a settled value;
    // a strap change afterwards is ignored until the next reset
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
            strap_held <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == vlm_pkg::STRAP_WAIT) begin
                strap_done <= 1'b1;
                strap_held <= strap_sync;
            end
        end
    end

    // vendor command overrides the strap when it forces a table
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            vid_protocol <= 1'b0;
        end else begin
            case (vendor_protocol_select_cmd)
                vlm_pkg::PSEL_FORCE_A: vid_protocol <= 1'b0;
                vlm_pkg::PSEL_FORCE_B: vid_protocol <= 1'b1;
                default:               vid_protocol <= strap_held;
            endcase
        end
    end

    // pick the target by operation mode, then clamp to the ceiling
    always_comb begin
        case (op_mode)
            vlm_pkg::OP_MARGIN_HIGH: requested = margin_high;
            vlm_pkg::OP_MARGIN_LOW:  requested = margin_low;
            default:                 requested = vout_cmd_vid;
        endcase
        over_ceiling = requested > ceiling;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            vid_target <= 8'h00;
        end else begin
            vid_target <= over_ceiling ? ceiling : requested;
        end
    end

    // telemetry plus offset, saturated to the signed 16-bit range
    always_comb begin
        iout_sum = 33'(signed'(iout_raw)) + 33'(cal_fix);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            iout_report <= 16'h0000;
        end else if (iout_sum > 33'sh0_0000_7fff) begin
            iout_report <= 16'h7fff;
        end else if (iout_sum < -33'sh0_0000_8000) begin
            iout_report <= 16'h8000;
        end else begin
            iout_report <= iout_sum[15:0];
        end
    end

    // power state: an overvoltage latches off with no timed retry
    always_comb begin
        case (state)
            vlm_pkg::ST_RUN: begin
                next_state = ov_sync ? vlm_pkg::ST_OV_OFF : vlm_pkg::ST_RUN;
            end
            vlm_pkg::ST_OV_OFF: begin
                // leave only when software clears and the sense line is quiet
                next_state = (fault_clear && !ov_sync) ? vlm_pkg::ST_RUN
                                                       : vlm_pkg::ST_OV_OFF;
            end
            default: begin
                next_state = vlm_pkg::ST_OV_OFF;
            end
        endcase
    end

    // switching follows the next state so it stops on the detect edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= vlm_pkg::ST_RUN;
            switch_enable <= 1'b1;
        end else begin
            state         <= next_state;
            switch_enable <= (next_state == vlm_pkg::ST_RUN);
        end
    end

    // sticky status: a set in the clear cycle wins over the clear
    always_comb begin
        next_byte = fault_clear ? 8'h00 : status_byte;
        next_vout = fault_clear ? 8'h00 : status_vout;
        if (ov_sync) begin
            next_byte[vlm_pkg::SB_VOUT_OV]  = 1'b1;
            next_vout[vlm_pkg::SV_OV_FAULT] = 1'b1;
        end
        if (over_ceiling) begin
            next_byte[vlm_pkg::SB_OTHER]    = 1'b1;
            next_vout[vlm_pkg::SV_MAX_WARN] = 1'b1;
        end
    end

    // status outputs and the open-drain alert, which only ever pulls low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            status_byte   <= 8'h00;
            status_vout   <= 8'h00;
            status_word   <= 16'h0000;
            host_alert_out <= 1'b0;
            host_alert_oe <= 1'b0;
        end else begin
            status_byte   <= next_byte;
            status_vout   <= next_vout;
            status_word   <= {|next_vout, 7'h00, next_byte};
            host_alert_out <= 1'b0;
            host_alert_oe <= |next_vout;
        end
    end

    property p_ceiling_read;
        @(posedge mclk) disable iff (sys_rst)
        cmd_rd && cmd_code == vlm_pkg::CMD_CEILING
        |=> rsp_valid && rsp_rdata == {8'h00, ceiling};
    endproperty
    a_ceiling_read: assert property (p_ceiling_read)
        else $error("ceiling read wrong or upper byte not zero");

    property p_margin_high;
        @(posedge mclk) disable iff (sys_rst)
        op_mode == vlm_pkg::OP_MARGIN_HIGH && margin_high <= ceiling
        |=> vid_target == $past(margin_high);
    endproperty
    a_margin_high: assert property (p_margin_high)
        else $error("margin high target not applied");

    property p_margin_low;
        @(posedge mclk) disable iff (sys_rst)
        op_mode == vlm_pkg::OP_MARGIN_LOW && margin_low <= ceiling
        |=> vid_target == $past(margin_low);
    endproperty
    a_margin_low: assert property (p_margin_low)
        else $error("margin low target not applied");

    property p_vid_write;
        @(posedge mclk) disable iff (sys_rst)
        cmd_wr && cmd_code == vlm_pkg::CMD_MARGIN_LOW
        ##1 cmd_rd && cmd_code == vlm_pkg::CMD_MARGIN_LOW
        |=> rsp_rdata == {8'h00, $past(cmd_wdata[7:0], 2)};
    endproperty
    a_vid_write: assert property (p_vid_write)
        else $error("VID word not stored right-justified");

    property p_protocol;
        @(posedge mclk) disable iff (sys_rst)
        vendor_protocol_select_cmd == vlm_pkg::PSEL_FORCE_B |=> vid_protocol;
    endproperty
    a_protocol: assert property (p_protocol)
        else $error("forced protocol not selected");

    property p_offset_add;
        @(posedge mclk) disable iff (sys_rst)
        cal_offset[15:11] == 5'h00 && cal_offset[10] == 1'b0
        && iout_raw[15:13] == 3'h0
        |=> iout_report == $past(iout_raw) + {$past(cal_offset[9:0]), 4'h0};
    endproperty
    a_offset_add: assert property (p_offset_add)
        else $error("current offset not added");

    property p_ov_off;
        @(posedge mclk) disable iff (sys_rst)
        ov_sync |=> !switch_enable ##1 !switch_enable;
    endproperty
    a_ov_off: assert property (p_ov_off)
        else $error("switching not stopped on overvoltage");

    property p_ov_status;
        @(posedge mclk) disable iff (sys_rst)
        ov_sync |=> status_byte[5] && status_word[15] && status_vout[7];
    endproperty
    a_ov_status: assert property (p_ov_status)
        else $error("overvoltage status bits not set");

    property p_ov_alert;
        @(posedge mclk) disable iff (sys_rst)
        ov_sync |=> host_alert_oe && !host_alert_out;
    endproperty
    a_ov_alert: assert property (p_ov_alert)
        else $error("alert not pulled on overvoltage");

    property p_no_restart;
        @(posedge mclk) disable iff (sys_rst)
        !switch_enable && !fault_clear |=> !switch_enable;
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("output restarted without fault clear");

    property p_clamp;
        @(posedge mclk) disable iff (sys_rst)
        over_ceiling |=> vid_target == $past(ceiling) && status_vout[3]
                         && status_byte[0] && host_alert_oe;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("over-ceiling request not clamped and flagged");

    property p_ov_action;
        @(posedge mclk) disable iff (sys_rst)
        cmd_rd && cmd_code == vlm_pkg::CMD_OV_ACTION
        |=> rsp_rdata == 16'h0080 && !rsp_nack;
    endproperty
    a_ov_action: assert property (p_ov_action)
        else $error("response register not fixed");
endmodule

// >>> test/vlm_host_model.sv
// host-side model of the register command port, one access at a time
// assumes the block answers with rsp_valid on the taking edge, read at the falling edge after it
`timescale 1ns/1ns
module vlm_host_model (
    input  wire logic        mclk,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_nack,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic        host_alert_out,
    input  wire logic        host_alert_oe,
    output logic             alert_wire,
    output logic [7:0]       cmd_code,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [15:0]      cmd_wdata
);
    // open-drain alert line with its pull-up on the host side
    assign alert_wire = host_alert_oe ? host_alert_out : 1'b1;

    initial begin
        cmd_code  = 8'h00;
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_wdata = 16'h0000;
    end

    // drop the strobes; idle lines show the inverse so stale samples are caught
    task automatic release_bus;
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask

    // called at a falling edge; gap 0 keeps the strobe up for a back-to-back access
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                          input int gap, output logic [15:0] rd, output logic nk,
                          output logic ok);
        if (gap > 0) begin
            release_bus();
            repeat (gap) @(negedge mclk);
        end
        cmd_code  = code;
        cmd_wdata = wd;
        cmd_wr    = wr;
        cmd_rd    = !wr;
        // the taking edge passes, the answer stands until the next one
        @(negedge mclk);
        ok = rsp_valid;
        nk = rsp_nack;
        rd = rsp_rdata;
    endtask
endmodule

// >>> test/test_vlm_regs.sv
// self-checking bench for the limit, margin, offset and overvoltage registers
// assumes vlm_pkg and the host model are compiled first
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) begin \
            errors++; \
            $display("ERROR %s expected %h seen %h", nm, ex, got); \
        end \
    end
module test_vlm_regs;
    logic        mclk, sys_rst, cmd_wr, cmd_rd, rsp_valid, rsp_nack, strap, ov_detect;
    logic        fault_clear, vid_protocol, switch_enable, host_alert_out, host_alert_oe;
    logic        alert_wire, warn;
    logic [7:0]  cmd_code, vout_cmd_vid, vid_target, status_byte, status_vout;
    logic [7:0]  ceil, mhi, mlo, sel;
    logic [1:0]  op_mode, vsel;
    logic [15:0] cmd_wdata, rsp_rdata, iout_raw, iout_report, status_word, ofs;
    logic [31:0] seed;      // lfsr state
    int          errors, tests_run, cycles, i;

    vlm_regs u_vlm_regs (.mclk(mclk), .sys_rst(sys_rst), .cmd_code(cmd_code),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .op_mode(op_mode),
        .vout_cmd_vid(vout_cmd_vid), .ramp_protocol_strap(strap),
        .vendor_protocol_select_cmd(vsel), .ov_detect(ov_detect), .fault_clear(fault_clear),
        .iout_raw(iout_raw), .iout_report(iout_report), .vid_target(vid_target),
        .vid_protocol(vid_protocol), .switch_enable(switch_enable),
        .status_byte(status_byte), .status_word(status_word), .status_vout(status_vout),
        .host_alert_out(host_alert_out), .host_alert_oe(host_alert_oe));

    vlm_host_model u_vlm_host_model (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
        .rsp_rdata(rsp_rdata), .host_alert_out(host_alert_out), .host_alert_oe(host_alert_oe),
        .alert_wire(alert_wire), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_wdata(cmd_wdata));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // galois lfsr, the only random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    // reported current in 1/16 A: raw plus m*2^e, floored and saturated
    function automatic int exp_iout(input logic [15:0] o, input logic [15:0] raw);
        int e, m, v;
        e = $signed(o[15:11]) + 4;
        m = $signed(o[10:0]);
        v = (e >= 0) ? (m <<< e) : (m >>> (-e));
        v = v + $signed(raw);
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // one checked access through the host model
    task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                       input logic [15:0] exp_rd, input logic exp_nk, input int gap);
        logic [15:0] rd;
        logic        nk, ok;
        u_vlm_host_model.access(wr, code, wd, gap, rd, nk, ok);
        `CHK("rsp_valid", 1'b1, ok)
        `CHK("rsp_nack", exp_nk, nk)
        `CHK("rsp_rdata", exp_rd, rd)
    endtask

    // a one-cycle pulse on fault_clear followed by two cycles of settling time
    task automatic clear_pulse;
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(2);
    endtask

    // hang guard: generous against the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        sys_rst = 1'b1; op_mode = 2'h0; vout_cmd_vid = 8'h10; strap = 1'b1; vsel = 2'h0;
        ov_detect = 1'b0; fault_clear = 1'b0; iout_raw = 16'h0000; seed = 32'h0000_e5fe;
        ceil = 8'hff; mhi = 8'h00; mlo = 8'h00;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        cyc(8);
        `CHK("switch_enable", 1'b1, switch_enable)
        // reset values, the fixed response and an unmapped code
        acc(1'b0, vlm_pkg::CMD_CEILING, 16'h0000, 16'h00ff, 1'b0, 1);
        acc(1'b0, vlm_pkg::CMD_MARGIN_HIGH, 16'h0000, 16'h0000, 1'b0, 0);
        acc(1'b0, vlm_pkg::CMD_MARGIN_LOW, 16'h0000, 16'h0000, 1'b0, 0);
        acc(1'b0, vlm_pkg::CMD_CAL_OFFSET, 16'h0000, 16'h0000, 1'b0, 0);
        acc(1'b0, vlm_pkg::CMD_OV_ACTION, 16'h0000, 16'h0080, 1'b0, 0);
        acc(1'b0, 8'h27, 16'h0000, 16'h0000, 1'b1, 0);
        seed = lfsr(seed);
        acc(1'b1, vlm_pkg::CMD_OV_ACTION, seed[15:0], 16'h0000, 1'b0, 1);
        acc(1'b0, vlm_pkg::CMD_OV_ACTION, 16'h0000, 16'h0080, 1'b0, 0);
        // random words with junk upper bytes, read back at once
        for (i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            sel = (i % 3 == 0) ? vlm_pkg::CMD_CEILING :
                  (i % 3 == 1) ? vlm_pkg::CMD_MARGIN_HIGH : vlm_pkg::CMD_MARGIN_LOW;
            acc(1'b1, sel, seed[15:0], 16'h0000, 1'b0, 1);
            acc(1'b0, sel, 16'h0000, {8'h00, seed[7:0]}, 1'b0, 0);
        end
        acc(1'b1, vlm_pkg::CMD_CEILING, 16'hff80, 16'h0000, 1'b0, 1);
        ceil = 8'h80;
        // a random ceiling above may have left a sticky warning; start clean
        u_vlm_host_model.release_bus();
        clear_pulse();
        // target selection, clamp and ceiling warning over random modes
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            mhi = seed[7:0];
            mlo = seed[15:8];
            acc(1'b1, vlm_pkg::CMD_MARGIN_HIGH, {seed[23:16], mhi}, 16'h0000, 1'b0, 1);
            acc(1'b1, vlm_pkg::CMD_MARGIN_LOW, {seed[31:24], mlo}, 16'h0000, 1'b0, 0);
            u_vlm_host_model.release_bus();
            op_mode = seed[21:20];
            vout_cmd_vid = seed[31:24];
            sel = (op_mode == 2'h1) ? mlo : (op_mode == 2'h2) ? mhi : vout_cmd_vid;
            warn = (sel > ceil);
            cyc(3);
            `CHK("vid_target", (warn ? ceil : sel), vid_target)
            `CHK("warn_vout", warn, status_vout[3])
            `CHK("warn_byte", warn, status_byte[0])
            `CHK("warn_word", warn, status_word[15])
            `CHK("warn_alert", !warn, alert_wire)
            op_mode = 2'h0;
            vout_cmd_vid = 8'h00;
            cyc(2);
            clear_pulse();
            `CHK("warn_clear", 8'h00, status_vout)
        end
        // calibration offset in linear form applied to the telemetry
        for (i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            // first pass: zero exponent, positive mantissa, small current
            ofs = (i == 0) ? {6'h00, seed[9:0]} : seed[15:0];
            acc(1'b1, vlm_pkg::CMD_CAL_OFFSET, ofs, 16'h0000, 1'b0, 1);
            acc(1'b0, vlm_pkg::CMD_CAL_OFFSET, 16'h0000, ofs, 1'b0, 0);
            u_vlm_host_model.release_bus();
            iout_raw = (i == 0) ? {3'h0, seed[28:16]} : seed[31:16];
            cyc(2);
            `CHK("iout_report", 16'(exp_iout(ofs, iout_raw)), iout_report)
        end
        // table selection; the strap was caught once after reset
        strap = 1'b0;
        for (i = 0; i < 4; i++) begin
            vsel = 2'(i);
            cyc(3);
            `CHK("vid_protocol", ((i == 1) ? 1'b0 : 1'b1), vid_protocol)
        end
        // overvoltage: latch off, status, alert, no restart
        ov_detect = 1'b1;
        cyc(4);
        `CHK("switch_enable", 1'b0, switch_enable)
        `CHK("ov_byte", 1'b1, status_byte[5])
        `CHK("ov_word", 1'b1, status_word[15])
        `CHK("ov_vout", 1'b1, status_vout[7])
        `CHK("ov_word_all", 16'h8020, status_word)
        `CHK("ov_alert", 1'b0, alert_wire)
        ov_detect = 1'b0;
        cyc(50);
        `CHK("no_restart", 1'b0, switch_enable)
        ov_detect = 1'b1;
        cyc(4);
        clear_pulse();
        `CHK("clear_under_ov", 1'b0, switch_enable)
        ov_detect = 1'b0;
        cyc(4);
        clear_pulse();
        `CHK("restart", 1'b1, switch_enable)
        `CHK("ov_cleared", 1'b0, status_vout[7])
        `CHK("alert_free", 1'b1, alert_wire)
        // second reset mid-run brings the ceiling back
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(8);
        acc(1'b0, vlm_pkg::CMD_CEILING, 16'h0000, 16'h00ff, 1'b0, 1);
        u_vlm_host_model.release_bus();
        cyc(2);
        tally_and_finish();
    end
endmodule
